// ### design/adsc_top.sv
// top: APB register file, flags, interrupt and first-result tracking around the sequencer
`timescale 1ns/1ps
// Notes on behaviour
// - channel rewrite leaves the done flag untouched.
// - a conversion in flight may still finish for the old channel.
// - first result marked suspect if started within 14 us of enable or disabled.
// - mode or channel write clears the result to zero.
// - sampling length chosen by the mode register field.
// - a start delay precedes sampling after enable.
// - mode or channel write in the completion cycle blocks update and interrupt.
module adsc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [9:0] ana_in,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic conv_end_irq
);
  import adsc_pkg::*;
  adsc_core_if cif ();

  logic [31:0] mode_r, mode_nxt;
  logic [CHAN_W-1:0] chan_r, chan_nxt;
  logic [RES_W-1:0] result_r, result_nxt;
  logic [1:0] status_r, status_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic [7:0] pfmode_r, pfmode_nxt;
  logic [7:0] pfthr_r, pfthr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic irq_r, irq_nxt;
  logic [15:0] settle_r, settle_nxt;
  logic suspect_r, suspect_nxt;
  logic first_r, first_nxt;

  // one-cycle answer: setup cycle arms pready, access cycle completes
  logic acc;
  logic wr;
  logic wr_cfg;
  assign acc = psel && penable && pready_r;
  assign wr = acc && pwrite;
  assign wr_cfg = wr && (paddr == OFS_MODE || paddr == OFS_CHAN);

  // address decode used by read and write paths
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == OFS_MODE) || (a == OFS_CHAN) || (a == OFS_RESULT) || (a == OFS_STATUS) ||
             (a == OFS_MASK) || (a == OFS_PFMODE) || (a == OFS_PFTHR);
  endfunction : mapped

  // sequencer hookup
  assign cif.start = mode_r[MODE_START_POS];
  assign cif.enable = mode_r[MODE_ENABLE_POS];
  assign cif.sample_sel = mode_r[MODE_SAMPLE_POS +: 2];
  assign cif.chan = chan_r;
  assign cif.ana_in = ana_in;

  adsc_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .cif(cif)
  );

  // completion is honoured only when no config write collides
  logic done_ok;
  assign done_ok = cif.done && !wr_cfg; // config write wins

  // register file and flags
  always_comb begin
    mode_nxt = mode_r;
    chan_nxt = chan_r;
    result_nxt = result_r;
    status_nxt = status_r;
    mask_nxt = mask_r;
    pfmode_nxt = pfmode_r;
    pfthr_nxt = pfthr_r;
    settle_nxt = settle_r;
    suspect_nxt = suspect_r;
    first_nxt = first_r;
    // settle timer runs from enable rising; cleared while disabled
    if (!mode_r[MODE_ENABLE_POS])
      settle_nxt = 16'h0000;
    else if (settle_r != 16'(SETTLE_CYC))
      settle_nxt = settle_r + 16'h0001;
    if (wr) begin
      case (paddr)
        OFS_MODE: begin
          mode_nxt = pwdata;
          // start set too early or with comparator off taints the first result
          if (pwdata[MODE_START_POS] && !mode_r[MODE_START_POS]) begin
            suspect_nxt = !pwdata[MODE_ENABLE_POS] || !mode_r[MODE_ENABLE_POS] ||
                          (settle_r != 16'(SETTLE_CYC));
            first_nxt = 1'b1;
          end
        end
        OFS_CHAN: chan_nxt = pwdata[CHAN_W-1:0]; // done flag not touched here
        OFS_STATUS: status_nxt = status_r & ~pwdata[1:0];
        OFS_MASK: mask_nxt = pwdata[1:0];
        OFS_PFMODE: pfmode_nxt = pwdata[7:0];
        OFS_PFTHR: pfthr_nxt = pwdata[7:0];
        default: ;
      endcase
    end
    // config write clears the result to zero
    if (wr_cfg)
      result_nxt = '0;
    // event set wins over a clear in the same cycle
    if (done_ok) begin
      result_nxt = cif.result;
      status_nxt[ST_DONE_POS] = 1'b1;
      if (first_r && suspect_r)
        status_nxt[ST_FIRST_POS] = 1'b1;
      first_nxt = 1'b0;
    end
  end

  // bus answer path
  always_comb begin
    pready_nxt = psel && !penable;
    pslverr_nxt = psel && !penable && !mapped(paddr);
    prdata_nxt = prdata_r;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_MODE: prdata_nxt = mode_r;
        OFS_CHAN: prdata_nxt = {29'h0000_0000, chan_r};
        OFS_RESULT: prdata_nxt = {22'h00_0000, result_r};
        OFS_STATUS: prdata_nxt = {29'h0000_0000, cif.busy, status_r};
        OFS_MASK: prdata_nxt = {30'h0000_0000, mask_r};
        OFS_PFMODE: prdata_nxt = {24'h00_0000, pfmode_r};
        OFS_PFTHR: prdata_nxt = {24'h00_0000, pfthr_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    irq_nxt = |(status_nxt & mask_nxt);
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_RST;
      chan_r <= '0;
      result_r <= '0;
      status_r <= 2'b00;
      mask_r <= MASK_RST[1:0];
      pfmode_r <= 8'h00;
      pfthr_r <= 8'h00;
      settle_r <= 16'h0000;
      suspect_r <= 1'b0;
      first_r <= 1'b0;
    end else if (ce) begin
      mode_r <= mode_nxt;
      chan_r <= chan_nxt;
      result_r <= result_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      pfmode_r <= pfmode_nxt;
      pfthr_r <= pfthr_nxt;
      settle_r <= settle_nxt;
      suspect_r <= suspect_nxt;
      first_r <= first_nxt;
    end
  end

  // bus answer and interrupt registers, kept apart so the answer path stays short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (ce) begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign conv_end_irq = irq_r;

  // channel write never clears done flag
  property p_chan_keeps_flag;
    @(posedge pclk) disable iff (!presetn)
      (ce && wr && paddr == OFS_CHAN && status_r[ST_DONE_POS]) |=> status_r[ST_DONE_POS];
  endproperty
  a_chan_keeps_flag: assert property (p_chan_keeps_flag) else $error("channel write cleared done flag");
  property p_collision;
    @(posedge pclk) disable iff (!presetn)
      (ce && cif.done && wr_cfg && !status_r[ST_DONE_POS]) |=> !status_r[ST_DONE_POS];
  endproperty
  a_collision: assert property (p_collision) else $error("done set despite config write");
  property p_done_same_cycle;
    @(posedge pclk) disable iff (!presetn)
      (ce && done_ok) |=> (status_r[ST_DONE_POS] && result_r == $past(cif.result));
  endproperty
  a_done_same_cycle: assert property (p_done_same_cycle) else $error("result and flag not together");
  property p_irq_level;
    @(posedge pclk) disable iff (!presetn) conv_end_irq == |(status_r & mask_r);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");
  property p_cfg_result;
    @(posedge pclk) disable iff (!presetn) (ce && wr_cfg) |=> result_r == '0;
  endproperty
  a_cfg_result: assert property (p_cfg_result) else $error("result kept after config write");
  property p_early_start;
    @(posedge pclk) disable iff (!presetn)
      (ce && wr && paddr == OFS_MODE && pwdata[MODE_START_POS] && !mode_r[MODE_START_POS] &&
       !pwdata[MODE_ENABLE_POS]) |=> suspect_r;
  endproperty
  a_early_start: assert property (p_early_start) else $error("start without enable not flagged");
  property p_apb_one_wait;
    @(posedge pclk) disable iff (!presetn) (ce && psel && !penable) |=> pready;
  endproperty
  a_apb_one_wait: assert property (p_apb_one_wait) else $error("pready late");

  // writing a one clears the done bit unless a completion lands in the same cycle
  property p_w1c_clear;
    @(posedge pclk) disable iff (!presetn)
      (ce && wr && paddr == OFS_STATUS && pwdata[ST_DONE_POS] && !done_ok) |=> !status_r[ST_DONE_POS];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("done bit survived its clear");
  // completion beats a clear written in the same cycle
  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
      (ce && done_ok && wr && paddr == OFS_STATUS) |=> status_r[ST_DONE_POS];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a completion");
  // unmapped address answers with an error
  property p_slverr_unmapped;
    @(posedge pclk) disable iff (!presetn) (ce && psel && !penable && !mapped(paddr)) |=> pslverr;
  endproperty
  a_slverr_unmapped: assert property (p_slverr_unmapped) else $error("no error on unmapped address");
  // pready stands for the access cycle only
  property p_pready_pulse;
    @(posedge pclk) disable iff (!presetn) (ce && psel && penable && pready) |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready held past access");
  // result moves only on a completion or a configuration write
  property p_result_hold;
    @(posedge pclk) disable iff (!presetn) (ce && !done_ok && !wr_cfg) |=> $stable(result_r);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed without cause");
  // start after a full settle with the comparator on gives a trusted first result
  property p_settled_clean;
    @(posedge pclk) disable iff (!presetn)
      (ce && wr && paddr == OFS_MODE && pwdata[MODE_START_POS] && pwdata[MODE_ENABLE_POS] &&
       !mode_r[MODE_START_POS] && mode_r[MODE_ENABLE_POS] && settle_r == 16'(SETTLE_CYC)) |=> !suspect_r;
  endproperty
  a_settled_clean: assert property (p_settled_clean) else $error("settled start marked suspect");
  // start inside the settle window taints the first result
  property p_early_enable;
    @(posedge pclk) disable iff (!presetn)
      (ce && wr && paddr == OFS_MODE && pwdata[MODE_START_POS] && !mode_r[MODE_START_POS] &&
       settle_r != 16'(SETTLE_CYC)) |=> suspect_r;
  endproperty
  a_early_enable: assert property (p_early_enable) else $error("early start not marked suspect");
  // settle timer saturates instead of wrapping back into the window
  property p_settle_cap;
    @(posedge pclk) disable iff (!presetn) settle_r <= 16'(SETTLE_CYC);
  endproperty
  a_settle_cap: assert property (p_settle_cap) else $error("settle timer past its ceiling");
  // disabling the comparator restarts the settle window
  property p_settle_clear;
    @(posedge pclk) disable iff (!presetn) (ce && !mode_r[MODE_ENABLE_POS]) |=> settle_r == 16'h0000;
  endproperty
  a_settle_clear: assert property (p_settle_clear) else $error("settle timer kept while disabled");
  // a tainted first completion raises the suspect bit
  property p_first_suspect;
    @(posedge pclk) disable iff (!presetn) (ce && done_ok && first_r && suspect_r) |=> status_r[ST_FIRST_POS];
  endproperty
  a_first_suspect: assert property (p_first_suspect) else $error("suspect bit not raised");
  // only the first completion after a start is judged
  property p_first_once;
    @(posedge pclk) disable iff (!presetn) (ce && done_ok) |=> !first_r;
  endproperty
  a_first_once: assert property (p_first_once) else $error("first marker kept after completion");
  // a channel rewrite does not abort the conversion in flight
  property p_chan_no_abort;
    @(posedge pclk) disable iff (!presetn)
      (ce && wr && paddr == OFS_CHAN && cif.busy && mode_r[MODE_START_POS] && mode_r[MODE_ENABLE_POS]) |=> cif.busy;
  endproperty
  a_chan_no_abort: assert property (p_chan_no_abort) else $error("channel write aborted conversion");
  // clearing start stops the sequencer at the next edge
  property p_mode_stop;
    @(posedge pclk) disable iff (!presetn) (ce && !mode_r[MODE_START_POS]) |=> !cif.busy;
  endproperty
  a_mode_stop: assert property (p_mode_stop) else $error("sequencer busy after stop");
  // power-fail mode takes the written byte
  property p_pfmode_wr;
    @(posedge pclk) disable iff (!presetn) (ce && wr && paddr == OFS_PFMODE) |=> pfmode_r == $past(pwdata[7:0]);
  endproperty
  a_pfmode_wr: assert property (p_pfmode_wr) else $error("power-fail mode not written");
  // a colliding config write raises no interrupt
  property p_collision_irq;
    @(posedge pclk) disable iff (!presetn) (ce && cif.done && wr_cfg && !conv_end_irq) |=> !conv_end_irq;
  endproperty
  a_collision_irq: assert property (p_collision_irq) else $error("interrupt despite config write");
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(conv_end_irq));
  c_collide: cover property (@(posedge pclk) disable iff (!presetn) cif.done && wr_cfg);
  c_suspect: cover property (@(posedge pclk) disable iff (!presetn) $rose(status_r[ST_FIRST_POS]));
endmodule : adsc_top

// ### common/adsc_pkg.sv
// package: register map, fields, reset values and timing for the converter sequencing control
package adsc_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned SETTLE_US = 14;
  localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int unsigned START_DELAY_CYC = 4;
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_CHAN = 12'h004;
  localparam logic [11:0] OFS_RESULT = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_MASK = 12'h010;
  localparam logic [11:0] OFS_PFMODE = 12'h014;
  localparam logic [11:0] OFS_PFTHR = 12'h018;
  localparam int unsigned MODE_START_POS = 0;
  localparam int unsigned MODE_ENABLE_POS = 1;
  localparam int unsigned MODE_SAMPLE_POS = 2;
  localparam int unsigned CHAN_W = 3;
  localparam int unsigned RES_W = 10;
  localparam int unsigned ST_DONE_POS = 0;
  localparam int unsigned ST_FIRST_POS = 1;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [7:0] SAMPLE_BASE_CYC = 8'h08;
  localparam logic [7:0] CONVERT_CYC = 8'h28;
  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONVERT, ST_DONE} adsc_state_t;
endpackage : adsc_pkg

// ### common/adsc_core_if.sv
// interface: control signals between register file and conversion sequencer
`timescale 1ns/1ps
interface adsc_core_if;
  logic start;
  logic enable;
  logic [1:0] sample_sel;
  logic [2:0] chan;
  logic [9:0] ana_in;
  logic busy;
  logic done;
  logic [9:0] result;
  modport regs (output start, enable, sample_sel, chan, ana_in, input busy, done, result);
  modport seq (input start, enable, sample_sel, chan, ana_in, output busy, done, result);
endinterface : adsc_core_if

// ### design/adsc_seq.sv
// conversion sequencer: start delay, sampling phase, conversion phase
`timescale 1ns/1ps
module adsc_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  adsc_core_if.seq cif
);
  import adsc_pkg::*;
  adsc_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [9:0] res_r, res_nxt;
  logic done_r, done_nxt;

  // sample length from mode field
  function automatic logic [7:0] sample_len(input logic [1:0] sel);
    sample_len = SAMPLE_BASE_CYC << sel;
  endfunction : sample_len

  // next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    res_nxt = res_r;
    done_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (cif.start && cif.enable) begin
          state_nxt = ST_DELAY; // sampling does not begin at once from idle; a restart from ST_DONE goes straight to ST_SAMPLE
          cnt_nxt = 8'(START_DELAY_CYC - 1);
        end
      end
      ST_DELAY: begin
        if (cnt_r == 8'h00) begin
          state_nxt = ST_SAMPLE;
          cnt_nxt = sample_len(cif.sample_sel) - 8'h01;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      ST_SAMPLE: begin
        if (cnt_r == 8'h00) begin
          state_nxt = ST_CONVERT;
          res_nxt = cif.ana_in; // input latched at end of sampling, old channel may finish
          cnt_nxt = CONVERT_CYC - 8'h01;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      ST_CONVERT: begin
        if (cnt_r == 8'h00) begin
          state_nxt = ST_DONE;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      ST_DONE: state_nxt = (cif.start && cif.enable) ? ST_SAMPLE : ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
    if (state_r == ST_DONE && cif.start && cif.enable)
      cnt_nxt = sample_len(cif.sample_sel) - 8'h01;
    if (!cif.start || !cif.enable) begin
      state_nxt = ST_IDLE;
      done_nxt = 1'b0;
    end
  end

  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      res_r <= 10'h000;
      done_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      res_r <= res_nxt;
      done_r <= done_nxt;
    end
  end

  assign cif.busy = (state_r != ST_IDLE);
  assign cif.done = done_r;
  assign cif.result = res_r;

  // done pulses only after a full conversion phase
  property p_done_after_convert;
    @(posedge pclk) disable iff (!presetn) $rose(done_r) |-> $past(state_r) == ST_CONVERT;
  endproperty
  a_done_after_convert: assert property (p_done_after_convert) else $error("done without conversion");
  property p_delay_first;
    @(posedge pclk) disable iff (!presetn)
      (ce && state_r == ST_IDLE && state_nxt != ST_IDLE) |=> state_r == ST_DELAY;
  endproperty
  a_delay_first: assert property (p_delay_first) else $error("sampling began without delay");
  c_conv_done: cover property (@(posedge pclk) disable iff (!presetn) $rose(done_r));
endmodule : adsc_seq

// ### test/tb.sv
// testbench: self-checking scenarios for the converter sequencing control over apb
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
  $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module tb;
  import adsc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [9:0] ana_in = 10'h2a5;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic conv_end_irq;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic er;

  adsc_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .ana_in(ana_in), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_end_irq(conv_end_irq));

  // 125 mhz clock
  always #4 pclk = ~pclk;

  task automatic close_out;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // hang guard: whole run is a few thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000, rd, er);
  endtask : rdr

  // bounded wait on the level interrupt
  task automatic wait_irq(output int n);
    n = 0;
    while (conv_end_irq !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_irq

  task automatic t_reset;
    rdr(OFS_MODE);
    `CHK("mode reset", MODE_RST, rd)
    rdr(OFS_MASK);
    `CHK("mask reset", MASK_RST, rd)
    rdr(OFS_STATUS);
    `CHK("status reset", 32'h0000_0000, rd)
    `CHK("pslverr mapped", 1'b0, er)
    wr(12'h01c, 32'h0000_00ff);
    `CHK("pslverr unmapped wr", 1'b1, er)
    rdr(12'h01c);
    `CHK("pslverr unmapped rd", 1'b1, er)
    `CHK("unmapped data", 32'h0000_0000, rd)
  endtask : t_reset

  // start with enable in the same write: interrupt, done and suspect set, then cleared
  task automatic t_first;
    int n;
    wr(OFS_MASK, 32'h0000_0003);
    wr(OFS_MODE, 32'h0000_0003);
    wait_irq(n); // end request polled, first result only judged, not used
    `CHK("irq on done", 1'b1, conv_end_irq)
    wr(OFS_MODE, 32'h0000_0002);
    rdr(OFS_STATUS);
    `CHK("done flag", 1'b1, rd[ST_DONE_POS])
    `CHK("first suspect", 1'b1, rd[ST_FIRST_POS])
    wr(OFS_STATUS, 32'h0000_0003);
    rdr(OFS_STATUS);
    `CHK("status cleared", 2'b00, rd[1:0])
    repeat (2) @(posedge pclk);
    `CHK("irq cleared", 1'b0, conv_end_irq)
  endtask : t_first

  // channel rewrite mid-conversion still completes; result read before the next mode or channel write
  task automatic t_chan;
    int n;
    ana_in <= 10'h13c;
    wr(OFS_MODE, 32'h0000_0003);
    wr(OFS_CHAN, 32'h0000_0005);
    wait_irq(n);
    `CHK("old channel completes", 1'b1, conv_end_irq)
    rdr(OFS_RESULT); // read after completion, before the next mode or channel write
    `CHK("result value", 32'h0000_013c, rd)
    wr(OFS_MODE, 32'h0000_0002);
    wr(OFS_CHAN, 32'h0000_0003);
    rdr(OFS_STATUS);
    `CHK("done kept on chan write", 1'b1, rd[ST_DONE_POS])
    rdr(OFS_RESULT);
    `CHK("result after chan write", 32'h0000_0000, rd)
    rdr(OFS_CHAN);
    `CHK("chan readback", 32'h0000_0003, rd)
  endtask : t_chan

  // channel write lands in the completion cycle; then a held clock enable stalls a run
  task automatic t_collide;
    int n;
    wr(OFS_MODE, 32'h0000_0002);
    wr(OFS_STATUS, 32'h0000_0003);
    wr(OFS_MASK, 32'h0000_0001);
    wr(OFS_MODE, 32'h0000_0003);
    repeat (START_DELAY_CYC + SAMPLE_BASE_CYC + CONVERT_CYC - 1) @(posedge pclk);
    wr(OFS_CHAN, 32'h0000_0002);
    rdr(OFS_STATUS);
    `CHK("collision no flag", 1'b0, rd[ST_DONE_POS])
    `CHK("collision no irq", 1'b0, conv_end_irq)
    wr(OFS_MODE, 32'h0000_0002);
    wr(OFS_STATUS, 32'h0000_0003);
    wr(OFS_MODE, 32'h0000_0003);
    ce <= 1'b0; // no register access while the block's clock is held off
    repeat (100) @(posedge pclk);
    `CHK("frozen irq", 1'b0, conv_end_irq)
    ce <= 1'b1;
    wait_irq(n);
    `CHK("frozen run length", START_DELAY_CYC + SAMPLE_BASE_CYC + CONVERT_CYC + 3, n)
    wr(OFS_MODE, 32'h0000_0000);
  endtask : t_collide

  // sampling length follows the select field; delay before sampling
  task automatic t_sel;
    int base;
    int n;
    for (int s = 0; s < 4; s++) begin
      wr(OFS_MODE, 32'h0000_0002);
      wr(OFS_STATUS, 32'h0000_0003);
      wr(OFS_MASK, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      wr(OFS_MODE, 32'h0000_0003 | (s << MODE_SAMPLE_POS));
      wait_irq(n);
      if (s == 0) begin
        base = n;
        `CHK("start delay kept", 1'b1, (n >= 52))
      end else begin
        `CHK("sample length", (8 << s) - 8, n - base)
      end
    end
    wr(OFS_MODE, 32'h0000_0002);
  endtask : t_sel

  // settled enable: no suspect mark; mask hides the done bit
  task automatic t_settled;
    int n;
    wr(OFS_MODE, 32'h0000_0000);
    wr(OFS_MODE, 32'h0000_0002);
    repeat (SETTLE_CYC + 50) @(posedge pclk);
    wr(OFS_STATUS, 32'h0000_0003);
    wr(OFS_MASK, 32'h0000_0002);
    wr(OFS_MODE, 32'h0000_0003);
    n = 0;
    rd = 32'h0000_0000;
    while (rd[ST_DONE_POS] !== 1'b1 && n < 200) begin
      rdr(OFS_STATUS);
      n++;
    end
    `CHK("settled done", 1'b1, rd[ST_DONE_POS])
    `CHK("settled no suspect", 1'b0, rd[ST_FIRST_POS])
    repeat (2) @(posedge pclk);
    `CHK("masked irq", 1'b0, conv_end_irq)
    wr(OFS_MODE, 32'h0000_0000);
  endtask : t_settled

  // main sequence: two-cycle reset, then scenarios
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_first();
    t_chan();
    t_sel();
    t_settled();
    t_collide();
    close_out();
  end
endmodule : tb
